/* File: adc_link_if.sv */
/*
 * the serial link between converter and master: select, serial clock
 * and the three-signal serial data pin. the bus level is resolved here.
 * assumes the testbench instantiates it and joins both ends.
 */
`timescale 1ns/1ps
`default_nettype none
interface adc_link_if;
	logic select_n;
	logic sclk;
	logic serial_out;
	logic serial_out_oe;
	logic serial_in;

	// released pin floats; model it as a pulled-up level for the master
	assign serial_in = serial_out_oe ? serial_out : 1'b1;

	modport dev (input select_n, input sclk, output serial_out, output serial_out_oe);
	modport mst (output select_n, output sclk, input serial_in);
endinterface
`default_nettype wire

/* File: adc_seq_assertions.sv */
/*
 * concurrent checks on the serial link between converter and master.
 * assumes it is instantiated in the testbench beside the link interface,
 * with the same clock and reset as both ends.
 */
`timescale 1ns/1ps
`default_nettype none
module adc_seq_assertions
	import adc_seq_pkg::*;
(
	// clock and reset
	input  wire logic clk_i,
	input  wire logic resetn_i,
	// link
	input  wire logic select_n,
	input  wire logic sclk,
	input  wire logic serial_out,
	input  wire logic serial_out_oe
);
	// ==========================================================
	// helper counters
	logic       sclk_q_ff;
	logic [4:0] falls_ff;
	logic [4:0] nxt_falls;
	logic [7:0] high_ff;
	logic [7:0] nxt_high;

	always_comb begin
		nxt_falls = select_n ? 5'h00 : falls_ff + {4'h0, sclk_q_ff & ~sclk};
		// saturate so a long idle spell never wraps below the track time
		nxt_high = !select_n ? 8'h00 : (high_ff == 8'hFF) ? high_ff : high_ff + 8'h01;
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			sclk_q_ff <= 1'b1;
			falls_ff  <= 5'h00;
			high_ff   <= 8'h00;
		end else begin
			sclk_q_ff <= sclk;
			falls_ff  <= nxt_falls;
			high_ff   <= nxt_high;
		end
	end

	// ==========================================================
	// link properties
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!resetn_i);

	AST_PIN_RELEASED: assert property (select_n [*6] |-> !serial_out_oe)
		else $error("data pin driven while deselected");
	AST_PIN_DRIVEN: assert property (!select_n [*6] |-> serial_out_oe)
		else $error("data pin not driven inside frame");
	AST_LEAD_ZERO: assert property ($fell(sclk) && falls_ff < 5'h04 |-> ##5 !serial_out)
		else $error("leading bit not zero");
	AST_DATA_STABLE: assert property ($fell(sclk) ##5 !select_n |-> $stable(serial_out) [*5])
		else $error("data changed away from falling clock");
	AST_SCLK_IDLE: assert property (select_n && $past(select_n) |-> sclk)
		else $error("serial clock moves outside frame");
	AST_SELECT_SETUP: assert property ($fell(select_n) |-> sclk [*8])
		else $error("serial clock fell too soon after select");
	AST_SCLK_HALF: assert property ($fell(sclk) |-> !sclk [*8] ##3 sclk)
		else $error("serial clock half period wrong");
	AST_FRAME_LEN: assert property ($rose(select_n) |-> falls_ff <= 5'h10 && falls_ff != 5'h00)
		else $error("frame clock count out of range");
	AST_TRACK_GAP: assert property ($fell(select_n) |-> high_ff >= 8'(TRACK_CYC))
		else $error("track time too short");

	COV_FULL: cover property ($rose(select_n) && falls_ff == 5'h10);
	COV_SHORT: cover property ($rose(select_n) && falls_ff < 5'h10);
	COV_START: cover property ($fell(select_n));
endmodule
`default_nettype wire

/* File: adc_seq_dev.sv */
/*
 * converter end: sequences tracking, warm-up, twelve decisions and
 * serial readout from the select and serial clock of the link.
 * assumes the master keeps its own timing; select and serial clock are
 * asynchronous to clk_i and are synchronised here.
 */
// How it works
// - select high: comparator off, capacitors tracking
// - select falling freezes the tracked value
// - master gives sixteen clocks per frame; here clocks_i of 1 to 15 gives fewer
// - first three clocks warm up comparator
// - twelve decisions, one per clock
// - each decision output one clock later
// - last decision clock fifteen, then track
// - final bit shown in sixteenth clock
// - after last bit, output drives zero
// - select high releases the data pin
// - power-on reset about 2.5 ms first
// - master runs one discarded dummy conversion
// - dummy lasts 1.6 us, finish first
// - then select alone picks track or convert
// - at least 200 ns tracking before conversion
// - acquisition at most 200 ns for top rate
// - early select rise cuts resolution short
// - output changes on falling clock edges
// - result coded in two's complement
// - serial clock between 10 kHz and 10 MHz
`timescale 1ns/1ps
`default_nettype none
module adc_seq_dev
	import adc_seq_pkg::*;
#(
	parameter int POR_CYCLES = POR_CYC
) (
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        resetn_i,
	// link
	adc_link_if.dev          link,
	// analog stand-in: the sample to convert, two's complement
	input  wire logic [11:0] sample_i,
	// status
	output logic             comp_on_o,
	output logic             tracking_o,
	output logic             ready_o
);

	// ==========================================================
	// synchronisers
	logic [1:0] sel_sync_ff;
	logic [1:0] clk_sync_ff;
	logic       sel_d_ff;
	logic       clk_d_ff;

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			sel_sync_ff <= 2'h3;
			clk_sync_ff <= 2'h0;
			sel_d_ff    <= 1'b1;
			clk_d_ff    <= 1'b0;
		end else begin
			sel_sync_ff <= {sel_sync_ff[0], link.select_n};
			clk_sync_ff <= {clk_sync_ff[0], link.sclk};
			sel_d_ff    <= sel_sync_ff[1];
			clk_d_ff    <= clk_sync_ff[1];
		end
	end

	logic sel_low;
	logic sel_fall;
	logic sclk_fall;
	assign sel_low   = !sel_sync_ff[1];
	assign sel_fall  = sel_d_ff && !sel_sync_ff[1];
	assign sclk_fall = clk_d_ff && !clk_sync_ff[1];

	// ==========================================================
	// sequencer
	dev_state_t  state_ff, nxt_state;
	logic [31:0] por_cnt_ff, nxt_por_cnt;
	logic [4:0]  edge_cnt_ff, nxt_edge_cnt;
	logic [11:0] held_ff, nxt_held;
	logic [11:0] shift_ff, nxt_shift;
	logic        dec_bit_ff, nxt_dec_bit;
	logic        dec_valid_ff, nxt_dec_valid;
	logic        out_ff, nxt_out;
	logic        oe_ff, nxt_oe;
	logic        comp_on_ff, nxt_comp_on;
	logic        track_ff, nxt_track;
	logic        ready_ff, nxt_ready;

	always_comb begin
		nxt_state     = state_ff;
		nxt_por_cnt   = por_cnt_ff;
		nxt_edge_cnt  = edge_cnt_ff;
		nxt_held      = held_ff;
		nxt_shift     = shift_ff;
		nxt_dec_bit   = dec_bit_ff;
		nxt_dec_valid = dec_valid_ff;
		nxt_out       = out_ff;
		nxt_oe        = oe_ff;
		nxt_comp_on   = comp_on_ff;
		nxt_track     = track_ff;
		nxt_ready     = ready_ff;
		case (state_ff)
			DEV_POR: begin
				nxt_oe      = 1'b0;
				nxt_track   = 1'b1;
				nxt_comp_on = 1'b0;
				if (por_cnt_ff >= 32'(POR_CYCLES - 1)) begin
					nxt_ready = 1'b1;
					nxt_state = DEV_TRACK;
				end else begin
					nxt_por_cnt = por_cnt_ff + 32'h00000001;
				end
			end
			DEV_TRACK: begin
				nxt_comp_on = 1'b0;
				nxt_track   = 1'b1;
				nxt_oe      = 1'b0;
				if (sel_fall) begin
					nxt_held      = sample_i;
					nxt_track     = 1'b0;
					nxt_comp_on   = 1'b1;
					nxt_edge_cnt  = CNT_RST;
					nxt_dec_valid = 1'b0;
					nxt_out       = 1'b0;
					nxt_oe        = 1'b1;
					nxt_state     = DEV_WARM;
				end
			end
			DEV_WARM, DEV_CONV, DEV_ZERO: begin
				if (!sel_low) begin
					// release pin; short cycle ends frame
					nxt_oe      = 1'b0;
					nxt_comp_on = 1'b0;
					nxt_track   = 1'b1;
					nxt_state   = DEV_TRACK;
				end else if (sclk_fall) begin
					nxt_edge_cnt = edge_cnt_ff + 5'h01;
					// previous decision shown on falling edge
					nxt_out      = dec_valid_ff ? dec_bit_ff : 1'b0;
					nxt_dec_valid = 1'b0;
					if (state_ff == DEV_WARM) begin
						if (edge_cnt_ff == 5'(WARMUP_CLKS - 1)) begin
							nxt_shift = held_ff;
							nxt_state = DEV_CONV;
						end
					end else if (state_ff == DEV_CONV) begin
						// one bit per clock, msb first
						nxt_dec_bit   = shift_ff[RES_BITS-1];
						nxt_dec_valid = 1'b1;
						nxt_shift     = {shift_ff[RES_BITS-2:0], 1'b0};
						if (edge_cnt_ff == 5'(LAST_DEC_CLK - 1)) begin
							nxt_comp_on = 1'b0;
							nxt_track   = 1'b1;
							nxt_state   = DEV_ZERO;
						end
					end
				end
			end
			default: nxt_state = DEV_POR;
		endcase
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state_ff     <= DEV_POR;
			por_cnt_ff   <= 32'h00000000;
			edge_cnt_ff  <= CNT_RST;
			held_ff      <= RESULT_RST;
			shift_ff     <= RESULT_RST;
			dec_bit_ff   <= 1'b0;
			dec_valid_ff <= 1'b0;
			out_ff       <= 1'b0;
			oe_ff        <= 1'b0;
			comp_on_ff   <= 1'b0;
			track_ff     <= 1'b1;
			ready_ff     <= 1'b0;
		end else begin
			state_ff     <= nxt_state;
			por_cnt_ff   <= nxt_por_cnt;
			edge_cnt_ff  <= nxt_edge_cnt;
			held_ff      <= nxt_held;
			shift_ff     <= nxt_shift;
			dec_bit_ff   <= nxt_dec_bit;
			dec_valid_ff <= nxt_dec_valid;
			out_ff       <= nxt_out;
			oe_ff        <= nxt_oe;
			comp_on_ff   <= nxt_comp_on;
			track_ff     <= nxt_track;
			ready_ff     <= nxt_ready;
		end
	end

	// ==========================================================
	// outputs
	assign link.serial_out    = out_ff;
	assign link.serial_out_oe = oe_ff;
	assign comp_on_o          = comp_on_ff;
	assign tracking_o         = track_ff;
	assign ready_o            = ready_ff;

endmodule
`default_nettype wire

/* File: adc_seq_mst.sv */
/*
 * master end: waits out power-on, runs one discarded dummy frame, then
 * converts on request with a guaranteed track time between frames.
 * assumes a 200 MHz clk_i; the serial clock is divided from it.
 */
`timescale 1ns/1ps
`default_nettype none
module adc_seq_mst
	import adc_seq_pkg::*;
#(
	parameter int POR_CYCLES = POR_CYC
) (
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        resetn_i,
	// link
	adc_link_if.mst          link,
	// user side
	input  wire logic        start_i,
	input  wire logic [4:0]  clocks_i,
	output logic             busy_o,
	output logic             done_o,
	output logic [11:0]      result_o,
	output logic             init_done_o
);

	// ==========================================================
	// data input synchroniser
	logic [1:0] din_sync_ff;
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			din_sync_ff <= 2'h0;
		end else begin
			din_sync_ff <= {din_sync_ff[0], link.serial_in};
		end
	end

	// ==========================================================
	// sequencer
	mst_state_t  state_ff, nxt_state;
	logic [31:0] cnt_ff, nxt_cnt;
	logic [4:0]  edges_ff, nxt_edges;
	logic [4:0]  target_ff, nxt_target;
	logic [15:0] shreg_ff, nxt_shreg;
	logic        dummy_ff, nxt_dummy;
	logic        sel_ff, nxt_sel;
	logic        sclk_ff, nxt_sclk;
	logic        busy_ff, nxt_busy;
	logic        done_ff, nxt_done;
	logic [11:0] res_ff, nxt_res;
	logic        init_ff, nxt_init;

	always_comb begin
		nxt_state  = state_ff;
		nxt_cnt    = cnt_ff;
		nxt_edges  = edges_ff;
		nxt_target = target_ff;
		nxt_shreg  = shreg_ff;
		nxt_dummy  = dummy_ff;
		nxt_sel    = sel_ff;
		nxt_sclk   = sclk_ff;
		nxt_busy   = busy_ff;
		nxt_done   = 1'b0;
		nxt_res    = res_ff;
		nxt_init   = init_ff;
		case (state_ff)
			MST_POR: begin
				nxt_busy = 1'b1;
				if (cnt_ff >= 32'(POR_CYCLES - 1)) begin
					nxt_dummy  = 1'b1;
					nxt_target = 5'(FRAME_CLKS);
					nxt_sel    = 1'b0;
					nxt_cnt    = 32'h00000000;
					nxt_edges  = CNT_RST;
					nxt_state  = MST_HIGH;
				end else begin
					nxt_cnt = cnt_ff + 32'h00000001;
				end
			end
			MST_IDLE: begin
				nxt_busy = 1'b0;
				if (start_i) begin
					nxt_busy   = 1'b1;
					nxt_dummy  = 1'b0;
					// fewer clocks gives a short-cycled result
					nxt_target = (clocks_i == 5'h00 || clocks_i > 5'(FRAME_CLKS)) ?
					             5'(FRAME_CLKS) : clocks_i;
					nxt_sel    = 1'b0;
					nxt_cnt    = 32'h00000000;
					nxt_edges  = CNT_RST;
					nxt_shreg  = 16'h0000;
					nxt_state  = MST_HIGH;
				end
			end
			// half periods keep the clock at 10 MHz
			MST_HIGH: begin
				if (cnt_ff >= 32'(SCLK_HALF_CYC - 1)) begin
					nxt_cnt   = 32'h00000000;
					nxt_sclk  = 1'b0;
					nxt_edges = edges_ff + 5'h01;
					nxt_state = MST_LOW;
				end else begin
					nxt_cnt = cnt_ff + 32'h00000001;
				end
			end
			// sample on rising edge, synchroniser lag covered by half period
			MST_LOW: begin
				if (cnt_ff >= 32'(SCLK_HALF_CYC - 1)) begin
					nxt_cnt   = 32'h00000000;
					nxt_sclk  = 1'b1;
					nxt_shreg = {shreg_ff[14:0], din_sync_ff[1]};
					// target_ff clocks, dummy runs all sixteen
					if (edges_ff == target_ff) begin
						nxt_sel   = 1'b1;
						nxt_state = MST_GAP;
					end else begin
						nxt_state = MST_HIGH;
					end
				end else begin
					nxt_cnt = cnt_ff + 32'h00000001;
				end
			end
			MST_GAP: begin
				if (cnt_ff >= 32'(TRACK_CYC - 1)) begin
					nxt_cnt = 32'h00000000;
					if (dummy_ff) begin
						nxt_init = 1'b1;
					end else begin
						nxt_done = 1'b1;
						// result in the low twelve received bits
						nxt_res  = 12'(shreg_ff << (5'(FRAME_CLKS) - target_ff));
					end
					nxt_state = MST_IDLE;
				end else begin
					nxt_cnt = cnt_ff + 32'h00000001;
				end
			end
			default: nxt_state = MST_POR;
		endcase
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state_ff  <= MST_POR;
			cnt_ff    <= 32'h00000000;
			edges_ff  <= CNT_RST;
			target_ff <= CNT_RST;
			shreg_ff  <= 16'h0000;
			dummy_ff  <= 1'b0;
			sel_ff    <= 1'b1;
			sclk_ff   <= 1'b1;
			busy_ff   <= 1'b1;
			done_ff   <= 1'b0;
			res_ff    <= RESULT_RST;
			init_ff   <= 1'b0;
		end else begin
			state_ff  <= nxt_state;
			cnt_ff    <= nxt_cnt;
			edges_ff  <= nxt_edges;
			target_ff <= nxt_target;
			shreg_ff  <= nxt_shreg;
			dummy_ff  <= nxt_dummy;
			sel_ff    <= nxt_sel;
			sclk_ff   <= nxt_sclk;
			busy_ff   <= nxt_busy;
			done_ff   <= nxt_done;
			res_ff    <= nxt_res;
			init_ff   <= nxt_init;
		end
	end

	assign link.select_n = sel_ff;
	assign link.sclk     = sclk_ff;
	assign busy_o        = busy_ff;
	assign done_o        = done_ff;
	assign result_o      = res_ff;
	assign init_done_o   = init_ff;

endmodule
`default_nettype wire

/* File: adc_seq_pkg.sv */
/*
 * shared constants for the serial converter sequencer: frame lengths,
 * bit positions, timing figures and the cycle counts derived from them.
 * assumes a 200 MHz system clock on both ends.
 */
package adc_seq_pkg;

	// ==========================================================
	// frame layout
	localparam int          RES_BITS      = 12;
	localparam int          FRAME_CLKS    = 16;
	localparam int          WARMUP_CLKS   = 3;
	localparam int          LAST_DEC_CLK  = 15;
	localparam int          FIRST_OUT_CLK = 5;
	localparam logic [4:0]  CNT_RST       = 5'h00;
	localparam logic [11:0] RESULT_RST    = 12'h000;

	// ==========================================================
	// timing
	localparam int CLK_MHZ       = 200;
	localparam int POR_TIME_US   = 2500;
	localparam int POR_CYC       = POR_TIME_US * CLK_MHZ;
	localparam int TRACK_TIME_NS = 200;
	localparam int TRACK_CYC     = (TRACK_TIME_NS * CLK_MHZ + 999) / 1000;
	// serial clock half period: 10 MHz top rate needs 100 ns period
	localparam int SCLK_HALF_NS  = 50;
	localparam int SCLK_HALF_CYC = (SCLK_HALF_NS * CLK_MHZ + 999) / 1000;
	localparam int DUMMY_TIME_NS = 1600;

	typedef enum {DEV_POR, DEV_TRACK, DEV_WARM, DEV_CONV, DEV_ZERO} dev_state_t;
	typedef enum {MST_POR, MST_IDLE, MST_LOW, MST_HIGH, MST_GAP} mst_state_t;

endpackage

/* File: tb.sv */
/*
 * self-checking testbench: master and converter joined by the link.
 * assumes both ends share a short power-on count for simulation.
 */
`timescale 1ns/1ps
`default_nettype none
module tb;
	import adc_seq_pkg::*;
	localparam int POR_SIM = 50;

	logic        clk_i;
	logic        resetn_i;
	logic        start_i;
	logic [4:0]  clocks_i;
	logic [11:0] sample_i;
	logic [11:0] result_o;
	logic        comp_on_o;
	logic        tracking_o;
	logic        ready_o;
	logic        busy_o;
	logic        done_o;
	logic        init_done_o;
	int          fails;
	int          n_compared;
	int          frames;

	// ==========================================================
	// ends and checker
	adc_link_if adc_link_if_i ();

	adc_seq_dev #(.POR_CYCLES(POR_SIM)) adc_seq_dev_i (.clk_i(clk_i), .resetn_i(resetn_i),
		.link(adc_link_if_i.dev), .sample_i(sample_i), .comp_on_o(comp_on_o),
		.tracking_o(tracking_o), .ready_o(ready_o));

	adc_seq_mst #(.POR_CYCLES(POR_SIM)) adc_seq_mst_i (.clk_i(clk_i), .resetn_i(resetn_i),
		.link(adc_link_if_i.mst), .start_i(start_i), .clocks_i(clocks_i), .busy_o(busy_o),
		.done_o(done_o), .result_o(result_o), .init_done_o(init_done_o));

	adc_seq_assertions adc_seq_assertions_i (.clk_i(clk_i), .resetn_i(resetn_i),
		.select_n(adc_link_if_i.select_n), .sclk(adc_link_if_i.sclk),
		.serial_out(adc_link_if_i.serial_out), .serial_out_oe(adc_link_if_i.serial_out_oe));

	always @(negedge adc_link_if_i.select_n) frames++;

	// ==========================================================
	// helpers
	task automatic chk_val(input logic [11:0] got, input logic [11:0] exp);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic chk_bit(input logic got, input logic exp);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic stop_test;
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// a selector instead of a ref argument: port-driven variables are not taken by ref everywhere
	task automatic wait_flag(input bit want_init, input int limit);
		int t;
		for (t = 0; t < limit && (want_init ? init_done_o : done_o) !== 1'b1; t++) begin
			@(negedge clk_i);
		end
		if ((want_init ? init_done_o : done_o) !== 1'b1) begin
			fails++;
			stop_test();
		end
	endtask

	task automatic do_reset;
		resetn_i = 1'b0;
		repeat (4) @(negedge clk_i);
		frames = 0;
		resetn_i = 1'b1;
	endtask

	// ==========================================================
	// scenarios
	task automatic t_power_on;
		chk_bit(adc_link_if_i.serial_out_oe, 1'b0);
		chk_bit(init_done_o, 1'b0);
		wait_flag(1'b1, 5000);
		chk_val(12'(frames), 12'h001);
		chk_bit(ready_o, 1'b1);
		chk_bit(comp_on_o, 1'b0);
	endtask

	task automatic convert(input logic [4:0] n, input logic [11:0] smp, input logic [11:0] exp);
		sample_i = smp;
		clocks_i = n;
		start_i  = 1'b1;
		@(negedge adc_link_if_i.select_n);
		@(negedge clk_i);
		start_i = 1'b0;
		repeat (6) @(negedge clk_i);
		// the input moves after capture; the result must not follow it
		sample_i = ~smp;
		if (n == 5'h10) begin
			repeat (2) @(negedge adc_link_if_i.sclk);
			repeat (5) @(negedge clk_i);
			chk_bit(comp_on_o, 1'b1);
			chk_bit(tracking_o, 1'b0);
			repeat (13) @(negedge adc_link_if_i.sclk);
			repeat (6) @(negedge clk_i);
			chk_bit(adc_link_if_i.select_n, 1'b0);
			chk_bit(tracking_o, 1'b1);
			chk_bit(comp_on_o, 1'b0);
		end
		wait_flag(1'b0, 2000);
		chk_val(result_o, exp);
		chk_bit(busy_o, 1'b1);
		@(negedge clk_i);
		chk_bit(done_o, 1'b0);
		chk_bit(busy_o, 1'b0);
		chk_bit(adc_link_if_i.serial_out_oe, 1'b0);
		chk_bit(comp_on_o, 1'b0);
	endtask

	task automatic t_reset_mid;
		start_i  = 1'b1;
		clocks_i = 5'h10;
		@(negedge adc_link_if_i.select_n);
		repeat (60) @(negedge clk_i);
		start_i  = 1'b0;
		resetn_i = 1'b0;
		@(negedge clk_i);
		chk_bit(adc_link_if_i.serial_out_oe, 1'b0);
		chk_bit(adc_link_if_i.select_n, 1'b1);
		chk_bit(tracking_o, 1'b1);
		do_reset();
		t_power_on();
	endtask

	// ==========================================================
	// main sequence
	logic [11:0] smp_tab [4] = '{12'h7FF, 12'h800, 12'hA5C, 12'h001};
	logic [4:0]  len_tab [3] = '{5'h05, 5'h08, 5'h0D};

	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end

	initial begin
		#100us;
		fails++;
		stop_test();
	end

	initial begin
		resetn_i   = 1'b0;
		start_i    = 1'b0;
		clocks_i   = 5'h10;
		sample_i   = 12'h000;
		fails      = 0;
		n_compared = 0;
		frames     = 0;
		@(negedge clk_i);
		do_reset();
		t_power_on();
		// two's complement extremes and mixed codes, back to back
		for (int i = 0; i < 4; i++) begin
			convert(5'h10, smp_tab[i], smp_tab[i]);
		end
		// short cycles keep only the leading bits
		for (int i = 0; i < 3; i++) begin
			convert(len_tab[i], 12'hB6D, 12'hB6D & (12'hFFF << (16 - len_tab[i])));
		end
		// a zero clock count asks for a full frame
		convert(5'h00, 12'h3C6, 12'h3C6);
		t_reset_mid();
		convert(5'h10, 12'h5A3, 12'h5A3);
		stop_test();
	end
endmodule
`default_nettype wire
